/* File: hso_shutoff.v */
/*
  hardwired shutoff state logic of a servo drive: two redundant safety
  channels, glitch filter, enable/disable interlock, feedback, ready, brake.
  assumes the safety channels are asynchronous pins (high = current flows)
  and software reaches the registers as an AHB-Lite slave on hclk.
*/
// Design decisions made here: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ns
`include "hso_defs.vh"

module hso_shutoff #(
  parameter integer GLITCH_CYC   = (`HSO_CLK_HZ / 1000000) * `HSO_GLITCH_US,
  parameter integer CUT_CYC      = (`HSO_CLK_HZ / 1000000) * `HSO_CUT_US,
  parameter integer MISMATCH_CYC = `HSO_CLK_HZ * `HSO_MISMATCH_S
) (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  input  wire        safety_shutoff_in_a,
  input  wire        safety_shutoff_in_b,
  output wire        gate_drive_en_a,
  output wire        gate_drive_en_b,
  output reg         shutoff_feedback_out,
  output reg         drive_ready_out,
  output reg         brake_release_out,
  output reg         fault_out
);

  // ===========================================================
  // synchronisers and glitch filters
  // ===========================================================
  reg  [1:0]  sync1_q;
  reg  [1:0]  sync2_q;
  reg  [1:0]  filt_q;
  reg  [23:0] gcnt_q [0:1];

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_q <= 2'h0;
      sync2_q <= 2'h0;
    end else begin
      sync1_q <= {safety_shutoff_in_b, safety_shutoff_in_a}; // R16
      sync2_q <= sync1_q; // R16
    end
  end

  // an off level is believed only once it outlasts the glitch window;
  // an on level is taken at once so recovery adds no latency
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_filt
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          gcnt_q[gi] <= 24'h0;
          filt_q[gi] <= 1'b0;
        end else if (sync2_q[gi]) begin // R3
          gcnt_q[gi] <= 24'h0;
          filt_q[gi] <= 1'b1;
        end else if (gcnt_q[gi] < GLITCH_CYC[23:0]) begin
          gcnt_q[gi] <= gcnt_q[gi] + 24'h1; // R5
        end else begin
          filt_q[gi] <= 1'b0; // R5
        end
      end
    end
  endgenerate

  // filter delay is 0.5 ms plus a few cycles, well inside the 8 ms cut time
  wire both_on  = filt_q[0] & filt_q[1];
  wire both_off = ~filt_q[0] & ~filt_q[1];
  wire any_off  = ~both_on;

  // ===========================================================
  // register bus
  // ===========================================================
  reg        wr_pend_q;
  reg  [7:0] wr_addr_q;
  reg  [7:0] rd_addr_q;
  reg  [3:0] ctrl_q;
  reg  [31:0] rdata_q;

  wire acc    = hsel & hready & htrans[1];
  wire wr_now = wr_pend_q;
  wire cmd_wr = wr_now & (wr_addr_q == `HSO_REG_CMD);
  wire enable_cmd  = cmd_wr & (hwdata[7:0] == `HSO_CMD_ENABLE);
  wire disable_cmd = cmd_wr & (hwdata[7:0] == `HSO_CMD_DISABLE);
  wire clr_wr      = wr_now & (wr_addr_q == `HSO_REG_CLEAR);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      rd_addr_q <= 8'h00;
      ctrl_q    <= 4'h0;
    end else begin
      wr_pend_q <= acc & hwrite;
      if (acc) begin
        wr_addr_q <= haddr[7:0];
        rd_addr_q <= haddr[7:0];
      end
      if (wr_now && wr_addr_q == `HSO_REG_CTRL)
        ctrl_q <= hwdata[3:0];
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_q;

  // ===========================================================
  // drive state machine
  // ===========================================================
  reg  [1:0] state_q;
  reg  [1:0] state_d;
  reg        dis_seen_q;
  reg        en_blocked_q;
  reg        stop_flag_q;
  reg        cmd_warn_q;
  reg        mismatch_q;
  reg        standalone_hold_q;
  reg  [1:0] prev_filt_q;
  reg  [27:0] mis_cnt_q;
  reg  [23:0] cut_cnt_q;
  reg        power_cut_q;

  wire main_pwr   = ctrl_q[`HSO_CTL_MAIN_PWR];
  wire motion_on  = ctrl_q[`HSO_CTL_MOTION];
  wire standalone = ctrl_q[`HSO_CTL_STANDALN];
  wire in_shutoff = (state_q == `HSO_ST_SHUTOFF);
  wire enter_shut = any_off & ~in_shutoff;

  always @* begin
    state_d = state_q;
    case (state_q)
      `HSO_ST_SHUTOFF: begin
        // leave only when both on, a disable came first (or shutoff was entered
        // from gate block or from reset) and no enable came since
        if (both_on && dis_seen_q && !en_blocked_q) // R6 R7 R8
          state_d = `HSO_ST_GATEBLK;
      end
      `HSO_ST_GATEBLK: begin
        if (any_off)
          state_d = `HSO_ST_SHUTOFF; // R1
        else if (!main_pwr)
          state_d = `HSO_ST_GATEBLK;
        else if (enable_cmd && !standalone_hold_q)
          state_d = `HSO_ST_RUN;
      end
      `HSO_ST_RUN: begin
        if (any_off)
          state_d = `HSO_ST_SHUTOFF; // R1
        else if (disable_cmd)
          state_d = `HSO_ST_GATEBLK;
      end
      default: state_d = `HSO_ST_SHUTOFF;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q           <= `HSO_ST_SHUTOFF;
      dis_seen_q        <= 1'b1;
      en_blocked_q      <= 1'b0;
      stop_flag_q       <= 1'b0;
      cmd_warn_q        <= 1'b0;
      mismatch_q        <= 1'b0;
      standalone_hold_q <= 1'b0;
      prev_filt_q       <= 2'h0;
      mis_cnt_q         <= 28'h0;
    end else begin
      state_q     <= state_d;
      prev_filt_q <= filt_q;
      if (enter_shut) begin
        dis_seen_q   <= (state_q == `HSO_ST_GATEBLK); // R6
        en_blocked_q <= 1'b0;
      end else if (in_shutoff) begin
        if (disable_cmd) begin
          dis_seen_q   <= 1'b1; // R7 R8
          en_blocked_q <= 1'b0;
        end else if (enable_cmd) begin
          en_blocked_q <= 1'b1; // R7 R14
        end
      end
      // gate block without main power stays in gate block and clears dis_seen_q
      if (state_q == `HSO_ST_GATEBLK && !main_pwr && !enter_shut)
        dis_seen_q <= 1'b0; // R8
      stop_flag_q <= ~in_shutoff ? enter_shut | (stop_flag_q & any_off)
                                 : 1'b1; // R9
      if (enter_shut && (motion_on || state_q == `HSO_ST_RUN))
        cmd_warn_q <= 1'b1; // R10
      else if (clr_wr && hwdata[`HSO_CLR_WARN])
        cmd_warn_q <= 1'b0; // R11
      if (enter_shut && standalone)
        standalone_hold_q <= 1'b1; // R13
      else if (!standalone)
        standalone_hold_q <= 1'b0; // R13
      // mismatch timer runs while the two channels disagree
      if (filt_q[0] == filt_q[1])
        mis_cnt_q <= 28'h0;
      else if (mis_cnt_q < MISMATCH_CYC[27:0])
        mis_cnt_q <= mis_cnt_q + 28'h1; // R12
      if (filt_q[0] != filt_q[1] && mis_cnt_q >= MISMATCH_CYC[27:0])
        mismatch_q <= 1'b1; // R12
      else if (clr_wr && hwdata[`HSO_CLR_MISMATCH])
        mismatch_q <= 1'b0;
    end
  end

  // ===========================================================
  // power stage and outputs
  // ===========================================================
  // each channel gates its own half of the drive path directly
  assign gate_drive_en_a = filt_q[0] & (state_q == `HSO_ST_RUN); // R2
  assign gate_drive_en_b = filt_q[1] & (state_q == `HSO_ST_RUN); // R2

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cut_cnt_q            <= 24'h0;
      power_cut_q          <= 1'b1;
      shutoff_feedback_out <= 1'b0;
      drive_ready_out      <= 1'b0;
      brake_release_out    <= 1'b0;
      fault_out            <= 1'b0;
    end else begin
      if (!both_off)
        cut_cnt_q <= 24'h0;
      else if (cut_cnt_q < CUT_CYC[23:0])
        cut_cnt_q <= cut_cnt_q + 24'h1;
      // the cut counter is a backstop: once both channels have been off for
      // the full cut time the power stage is reported cut whatever the state
      power_cut_q          <= ~(gate_drive_en_a & gate_drive_en_b)
                              | (cut_cnt_q == CUT_CYC[23:0]); // R4
      shutoff_feedback_out <= both_off; // R17 R18
      // next state, so ready is already low in the cycle the gates open
      drive_ready_out      <= both_on & (state_d == `HSO_ST_GATEBLK)
                              & ~in_shutoff; // R14 R15
      brake_release_out    <= (state_d == `HSO_ST_RUN) & ~any_off; // R19
      fault_out            <= ctrl_q[`HSO_CTL_FAULT] & ~in_shutoff
                              & ~enter_shut; // R20
    end
  end

  // ===========================================================
  // read mux
  // ===========================================================
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= 32'h0;
    end else if (acc && !hwrite) begin
      case (haddr[7:0])
        `HSO_REG_STATUS:
          rdata_q <= {24'h0, power_cut_q, 1'b0, filt_q, 2'h0, state_q};
        `HSO_REG_MONITOR:
          rdata_q <= {29'h0, mismatch_q, cmd_warn_q, stop_flag_q};
        `HSO_REG_CTRL:
          rdata_q <= {28'h0, ctrl_q};
        default:
          rdata_q <= 32'h0;
      endcase
    end
  end

endmodule // hso_shutoff

/* File: hso_defs.vh */
/*
  constants for the hardwired shutoff state block: clock rate and timings, register
  offsets, command codes and field positions.
  assumes a 25 MHz control clock and an AHB-Lite register bus.
*/
//
// Summary of operation
// (R1) either safety channel going off enters the hardwired shutoff state
// (R2) each channel alone forces the power stage drive signals off
// (R3) current flowing means on; no current means off, the shutoff request
// (R4) both channels off cut motor power within 8 ms
// (R5) off pulses of 0.5 ms or less are ignored
// (R6) shutoff entered after disable, both on again: go to gate block, accept enable
// (R7) enable received while off keeps shutoff; host must send disable then enable
// (R8) gate block reached with main power off keeps shutoff until a disable; the code stays in gate block and refuses enable until main power is on
// (R9) entering shutoff sets the stop request flag in the command monitor
// (R10) shutoff during a motion or enable command raises a command warning
// (R11) host clears the warning, after stopping motion, to resume; the code accepts disable and enable with the warning still set
// (R12) one channel changing without the other within 10 s raises mismatch alarm
// (R13) shutoff acts standalone; standalone function restarts only on mode re-entry
// (R14) in shutoff the enable command is refused and ready is held off
// (R15) ready is on only with both channels on, disabled, in gate block
// (R16) safety channels are synchronised to the control clock before filtering
// (R17) both channels off turn the shutoff feedback output on within 8 ms
// (R18) shutoff feedback is on only when both channels are off
// (R19) entering shutoff drops brake release at once, skipping the brake delay
// (R20) the fault output is never asserted in the shutoff state
`ifndef HSO_DEFS_VH
`define HSO_DEFS_VH

`define HSO_CLK_HZ        25000000
`define HSO_GLITCH_US     500
`define HSO_CUT_US        8000
`define HSO_MISMATCH_S    10

// register byte offsets
`define HSO_REG_CMD       8'h00
`define HSO_REG_STATUS    8'h04
`define HSO_REG_MONITOR   8'h08
`define HSO_REG_CLEAR     8'h0c
`define HSO_REG_CTRL      8'h10

// command codes written to the command register
`define HSO_CMD_ENABLE    8'h31
`define HSO_CMD_DISABLE   8'h32

// monitor word fields
`define HSO_MON_STOP      0
`define HSO_MON_CMD_WARN  1
`define HSO_MON_MISMATCH  2

// control register fields
`define HSO_CTL_MAIN_PWR  0
`define HSO_CTL_MOTION    1
`define HSO_CTL_STANDALN  2
`define HSO_CTL_FAULT     3

// clear register fields
`define HSO_CLR_WARN      0
`define HSO_CLR_MISMATCH  1

// drive states
`define HSO_ST_SHUTOFF    2'h0
`define HSO_ST_GATEBLK    2'h1
`define HSO_ST_RUN        2'h2

`endif

/* File: hso_shutoff_sva.sv */
/* checker on the ports of hso_shutoff.
   assumes GLITCH_CYC of 8, so 15 low samples always count as off */
`timescale 1ns/1ns
module hso_shutoff_sva (
  input wire hclk,
  input wire hresetn,
  input wire hreadyout,
  input wire hresp,
  input wire safety_shutoff_in_a,
  input wire safety_shutoff_in_b,
  input wire gate_drive_en_a,
  input wire gate_drive_en_b,
  input wire shutoff_feedback_out,
  input wire drive_ready_out,
  input wire brake_release_out,
  input wire fault_out
);
  // ====
  // channel sequences
  wire a = safety_shutoff_in_a;
  wire b = safety_shutoff_in_b;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence a_off_s; (!a)[*8] ##1 (!a)[*7]; endsequence
  sequence both_off_s; (!a && !b)[*8] ##1 (!a && !b)[*7]; endsequence
  // ====
  // properties
  cut_gates_a: assert property (a_off_s |-> !gate_drive_en_a && !gate_drive_en_b)
    else $error("gate drive on with channel a off");
  feedback_on_a: assert property (both_off_s |-> shutoff_feedback_out)
    else $error("feedback off with both channels off");
  feedback_off_a: assert property (a[*8] |-> !shutoff_feedback_out)
    else $error("feedback on with channel a on");
  ready_off_a: assert property (a_off_s |-> !drive_ready_out)
    else $error("ready on in shutoff");
  brake_drop_a: assert property (a_off_s |-> !brake_release_out)
    else $error("brake released in shutoff");
  fault_quiet_a: assert property (a_off_s |-> !fault_out)
    else $error("fault shown in shutoff");
  ready_idle_a: assert property (drive_ready_out |-> !gate_drive_en_a && !gate_drive_en_b)
    else $error("ready on while driving");
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready okay");
endmodule // hso_shutoff_sva

bind hso_shutoff hso_shutoff_sva u_sva (.hclk, .hresetn, .hreadyout, .hresp,
  .safety_shutoff_in_a, .safety_shutoff_in_b, .gate_drive_en_a, .gate_drive_en_b,
  .shutoff_feedback_out, .drive_ready_out, .brake_release_out, .fault_out);

/* File: hso_safety_unit.sv */
/* model of the external safety unit on both channels.
   assumes the bench sets wanted levels; channel b may lag to act slowly */
`timescale 1ns/1ns
module hso_safety_unit (
  input  wire       hclk,
  input  wire       req_a,
  input  wire       req_b,
  input  wire [3:0] lag_b,
  output reg        safety_shutoff_in_a = 1'b0,
  output reg        safety_shutoff_in_b = 1'b0
);
  // ====
  // channel drive
  reg [15:0] hist_q = 16'h0;
  // high means current flows and the channel is on; low asks for shutoff
  always @(posedge hclk) begin
    hist_q <= {hist_q[14:0], req_b};
    safety_shutoff_in_a <= req_a;
    safety_shutoff_in_b <= (lag_b == 4'h0) ? req_b : hist_q[lag_b - 4'h1];
  end
endmodule // hso_safety_unit

/* File: test_hardwired_safe_torque_off.sv */
/* self-checking bench for hso_shutoff with shortened counts.
   assumes zero wait state bus answers and the safety unit model */
`timescale 1ns/1ns
module test_hardwired_safe_torque_off;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        req_a = 1'b1;
  logic        req_b = 1'b1;
  logic [3:0]  lag_b = 4'h0;
  logic [31:0] rd;
  wire  [31:0] hrdata;
  wire         hreadyout, hresp, sa, sb, ga, gb, fb, rdy, brk, flt;
  wire  [5:0]  pins = {ga, gb, fb, rdy, brk, flt};
  int          bad_count = 0;
  int          num_checks = 0;
  always #20 hclk = ~hclk;
  hso_shutoff #(.GLITCH_CYC(8), .CUT_CYC(16), .MISMATCH_CYC(64)) u_dut (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .safety_shutoff_in_a(sa),
    .safety_shutoff_in_b(sb), .gate_drive_en_a(ga), .gate_drive_en_b(gb),
    .shutoff_feedback_out(fb), .drive_ready_out(rdy), .brake_release_out(brk),
    .fault_out(flt));
  hso_safety_unit u_unit (.hclk(hclk), .req_a(req_a), .req_b(req_b), .lag_b(lag_b),
    .safety_shutoff_in_a(sa), .safety_shutoff_in_b(sb));
  // ====
  // shared tasks
  task test_done;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      bad_count++;
    end
  endtask
  task step(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task wait_rdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      if (++n > 50) begin
        bad_count++;
        test_done;
      end
      @(posedge hclk);
    end
  endtask
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    rd = hrdata;
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask
  // pins are looked at mid-cycle, away from the edge that launches them
  task pchk(input logic [5:0] e);
    @(negedge hclk);
    chk({26'h0, pins}, {26'h0, e});
    @(posedge hclk);
  endtask
  // ====
  // scenarios
  task t_idle;
    step(10);
    pchk(6'h04);
    rchk(8'h04, 32'h33, 32'h31);
    rchk(8'h08, 32'h7, 32'h0);
    rchk(8'h20, 32'hffffffff, 32'h0);
    bus(1'b1, 8'h10, 32'h1);
    rchk(8'h10, 32'hf, 32'h1);
  endtask
  task t_run;
    bus(1'b1, 8'h00, 32'h31);
    step(2);
    pchk(6'h32);
    req_a <= 1'b0;
    step(8);
    req_a <= 1'b1;
    step(20);
    rchk(8'h04, 32'h3, 32'h2);
  endtask
  task t_cut;
    bus(1'b1, 8'h10, 32'hb);
    step(2);
    pchk(6'h33);
    lag_b <= 4'h5;
    req_a <= 1'b0;
    req_b <= 1'b0;
    step(20);
    pchk(6'h08);
    rchk(8'h08, 32'h7, 32'h3);
    bus(1'b1, 8'h00, 32'h31);
    req_a <= 1'b1;
    req_b <= 1'b1;
    step(20);
    rchk(8'h04, 32'h3, 32'h0);
    pchk(6'h00);
    bus(1'b1, 8'h00, 32'h32);
    step(2);
    rchk(8'h04, 32'h3, 32'h1);
    bus(1'b1, 8'h0c, 32'h1);
    rchk(8'h08, 32'h3, 32'h0);
  endtask
  task t_mis;
    bus(1'b1, 8'h10, 32'h1);
    bus(1'b1, 8'h00, 32'h31);
    req_a <= 1'b0;
    step(20);
    pchk(6'h00);
    rchk(8'h08, 32'h7, 32'h3);
    step(80);
    rchk(8'h08, 32'h4, 32'h4);
    req_a <= 1'b1;
    step(20);
    bus(1'b1, 8'h0c, 32'h3);
    rchk(8'h08, 32'h6, 32'h0);
  endtask
  task t_solo;
    lag_b <= 4'h0;
    bus(1'b1, 8'h00, 32'h32);
    bus(1'b1, 8'h10, 32'h5);
    bus(1'b1, 8'h00, 32'h31);
    step(2);
    rchk(8'h04, 32'h3, 32'h2);
    req_a <= 1'b0;
    req_b <= 1'b0;
    step(20);
    pchk(6'h08);
    req_a <= 1'b1;
    req_b <= 1'b1;
    step(20);
    bus(1'b1, 8'h00, 32'h32);
    bus(1'b1, 8'h00, 32'h31);
    step(2);
    rchk(8'h04, 32'h3, 32'h1);
    bus(1'b1, 8'h10, 32'h1);
    bus(1'b1, 8'h00, 32'h31);
    step(2);
    rchk(8'h04, 32'h3, 32'h2);
  endtask
  initial begin
    step(8);
    hresetn <= 1'b1;
    t_idle;
    t_run;
    t_cut;
    t_mis;
    t_solo;
    test_done;
  end
endmodule // test_hardwired_safe_torque_off
